// [verilog/cfr_clock_ring.sv]
// Processor four-phase clock ring with run control and APB status/keys.
// Assumes a 50 MHz pclk, control lines synchronous to it, APB master.
//
// Overview of operation
// - 2 MHz oscillator drives four-latch phase ring
// - Oscillator gives true and complement, both lines
// - Latches on 500 ns, overlapping, distinct
// - Clock reset turns on latch 4
// - Clock reset turns off latches 1-3
// - Latch 1 sets: run, delayed edge, 3off, 4on
// - Latches set/reset on alternating delayed edges
// - Four phases on separate distribution lines
// - Phase 1 and 4 form slot 1
// - Halt, share hold, power off drop run
// - Hard halt clears latches 1-3 immediately
// - Run latch holds while stop, reset inactive
// - Start, load, address-load keys set run latch
// - Stop or reset line low clears run latch
// - Without run, ring stops after slot 4
// - I/O request extends running after latch reset
// - Slots feed channel and processor logic
`timescale 1ns/1ps
`include "cfr_cfg.svh"

module cfr_clock_ring (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Control lines
	input  wire logic        clock_reset,
	input  wire logic        run_stop_n,
	input  wire logic        run_reset_n,
	input  wire logic        hard_halt,
	input  wire logic        share_hold,
	input  wire logic        power_off,
	input  wire logic        io_run_extend,
	// Phase distribution lines
	output logic             phase_1,
	output logic             phase_2,
	output logic             phase_3,
	output logic             phase_4,
	// Timing slots
	output logic       [3:0] cpu_slot,
	output logic       [3:0] chan_slot,
	// Run state
	output logic             run_request,
	output logic             start_control_latch,
	output logic             exec_stop_sample_latch,
	output logic             load_latch,
	output logic             forced_address_load_request
);

	// ----------------------------------------------------------------
	// Oscillator and slot points
	// ----------------------------------------------------------------
	cfr_clk_if bus ();

	// Oscillator drive lines
	cfr_osc u_osc (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.bus     (bus)
	);

	// Slot forming for processor and channel
	cfr_slot_gen u_slot (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.bus       (bus),
		.cpu_slot  (cpu_slot),
		.chan_slot (chan_slot)
	);

	// ----------------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------------
	logic       apb_setup;  // First cycle of a transfer
	logic       apb_acc;    // Completing access phase
	logic       key_wr;     // Write to the key register
	logic [2:0] key;        // Key pulses, one cycle

	assign apb_setup = psel & ~penable;
	assign apb_acc   = psel & penable & pready;
	assign key_wr    = apb_acc & pwrite & (paddr == `CFR_ADDR_CTRL);
	assign key       = key_wr ? pwdata[2:0] : 3'h0;

	// ----------------------------------------------------------------
	// Run-request latch and key latches
	// ----------------------------------------------------------------
	logic run_latch;        // Run-request latch
	logic next_run_latch;
	logic next_run_request;
	logic next_sctl;
	logic next_exec;
	logic next_load;
	logic next_fal;
	logic key_any;          // Any key pressed this cycle

	// Latch-back, keys, and the stop/reset lines that win over keys
	always_comb begin
		key_any        = |key;
		next_run_latch = key_any | (run_latch & run_stop_n & run_reset_n);
		if (!run_stop_n || !run_reset_n || clock_reset) begin
			next_run_latch = 1'b0;
		end
		// Gated run line; any blocking condition drops it
		next_run_request = next_run_latch & ~hard_halt & ~share_hold & ~power_off;
		// Key side latches: set wins over the clock reset
		next_sctl = key[`CFR_KEY_START] | (start_control_latch & ~clock_reset);
		next_exec = key[`CFR_KEY_START] | (exec_stop_sample_latch & ~clock_reset);
		next_load = key[`CFR_KEY_LOAD] | (load_latch & ~clock_reset);
		next_fal  = key[`CFR_KEY_ALOAD] | (forced_address_load_request & ~clock_reset);
	end

	// Registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_latch                   <= 1'b0;
			run_request                 <= 1'b0;
			start_control_latch         <= 1'b0;
			exec_stop_sample_latch      <= 1'b0;
			load_latch                  <= 1'b0;
			forced_address_load_request <= 1'b0;
		end else if (ce) begin
			run_latch                   <= next_run_latch;
			run_request                 <= next_run_request;
			start_control_latch         <= next_sctl;
			exec_stop_sample_latch      <= next_exec;
			load_latch                  <= next_load;
			forced_address_load_request <= next_fal;
		end
	end

	// ----------------------------------------------------------------
	// Phase ring
	// ----------------------------------------------------------------
	cfr_pkg::cfr_ring_t ring;       // Ring latches, bit 0 is latch 1
	cfr_pkg::cfr_ring_t next_ring;
	logic               prev_dly;   // Last true delayed level
	logic               prev_dly_n; // Last complement delayed level
	logic               t_rise;     // Positive shift of true line
	logic               c_rise;     // Positive shift of complement line
	logic               run_go;     // Ring may start another cycle
	logic               l3_next;    // Latch 3 after this shift

	assign t_rise = bus.dly_osc & ~prev_dly;
	assign c_rise = bus.dly_osc_n & ~prev_dly_n;
	// I/O extension keeps the ring going but never through a hard halt
	assign run_go = run_request | (io_run_extend & ~hard_halt);

	// Odd latches move on complement shifts, even ones on true shifts
	always_comb begin
		next_ring = ring;
		l3_next   = (ring[2] | ring[1]) & ~ring[3];
		if (c_rise) begin
			next_ring[2] = l3_next;
			// Latch 3 going off this shift counts as off
			next_ring[0] = (ring[0] & ~ring[1]) | (run_go & ring[3] & ~l3_next);
		end
		if (t_rise) begin
			next_ring[1] = (ring[1] | ring[0]) & ~ring[2];
			next_ring[3] = (ring[3] | ring[2]) & ~next_ring[1];
		end
		// Stopping is natural: from slot 4 latch 1 stays off
		if (hard_halt) begin
			next_ring = `CFR_RING_RST;
		end
		if (clock_reset) begin
			next_ring = `CFR_RING_RST;
		end
	end

	// Registers only; power-on also leaves latch 4 on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring       <= `CFR_RING_RST;
			prev_dly   <= 1'b0;
			prev_dly_n <= 1'b1;
		end else if (ce) begin
			ring       <= next_ring;
			prev_dly   <= bus.dly_osc;
			prev_dly_n <= bus.dly_osc_n;
		end
	end

	// Four separate distribution lines
	assign bus.phase = ring;
	assign phase_1   = ring[0];
	assign phase_2   = ring[1];
	assign phase_3   = ring[2];
	assign phase_4   = ring[3];

	// ----------------------------------------------------------------
	// Status read and APB answer
	// ----------------------------------------------------------------
	cfr_pkg::cfr_slot_t slot_idx;   // Current slot, Gray coded
	logic [31:0]        stat;       // Status word
	logic [31:0]        next_prdata;
	logic               next_pready;
	logic               next_pslverr;
	logic               mapped;     // Address hits a register

	// Slot index from the processor slot lines
	always_comb begin
		case (cpu_slot)
			4'h2:    slot_idx = cfr_pkg::CFR_SLOT_2;
			4'h4:    slot_idx = cfr_pkg::CFR_SLOT_3;
			4'h8:    slot_idx = cfr_pkg::CFR_SLOT_4;
			default: slot_idx = cfr_pkg::CFR_SLOT_1;
		endcase
	end

	// Answer computed in setup so the access phase needs no wait
	always_comb begin
		stat = 32'h0;
		stat[`CFR_ST_RUNL] = run_latch;
		stat[`CFR_ST_RUNR] = run_request;
		stat[`CFR_ST_RING_HI:`CFR_ST_RING_LO] = ring;
		stat[`CFR_ST_SCTL] = start_control_latch;
		stat[`CFR_ST_EXEC] = exec_stop_sample_latch;
		stat[`CFR_ST_LOAD] = load_latch;
		stat[`CFR_ST_FAL]  = forced_address_load_request;
		stat[`CFR_ST_SLOT_HI:`CFR_ST_SLOT_LO] = slot_idx;
		stat[`CFR_ST_REF]   = bus.ref_osc;
		stat[`CFR_ST_REF_N] = bus.ref_osc_n;
		mapped       = (paddr == `CFR_ADDR_CTRL) || (paddr == `CFR_ADDR_STAT);
		next_pready  = apb_setup;
		next_pslverr = apb_setup & ~mapped;
		next_prdata  = 32'h0;
		// Key register reads zero; keys are pulses only
		if (apb_setup && !pwrite && paddr == `CFR_ADDR_STAT) begin
			next_prdata = stat;
		end
	end

	// Registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			prdata  <= next_prdata;
			pready  <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Latch 1 then latch 2 on the next true shift
	sequence s_l1_on;
		ce && c_rise && !clock_reset && !hard_halt && run_go && ring == `CFR_RING_RST;
	endsequence
	sequence s_l1_held;
		ring[0] && ring[3];
	endsequence

	property p_reset_l4;
		(ce && clock_reset) |=> (phase_4 && !phase_1 && !phase_2 && !phase_3);
	endproperty
	a_reset_l4: assert property (p_reset_l4) else $error("clock reset state wrong");

	property p_l1_start;
		s_l1_on |=> s_l1_held;
	endproperty
	a_l1_start: assert property (p_l1_start) else $error("latch 1 did not set");

	property p_l2_follow;
		(ce && t_rise && !clock_reset && !hard_halt && ring == 4'h9) |=> (ring == 4'h3);
	endproperty
	a_l2_follow: assert property (p_l2_follow) else $error("latch 2 or 4 wrong");

	property p_overlap;
		$rose(phase_2) |-> $past(phase_1);
	endproperty
	a_overlap: assert property (p_overlap) else $error("phase 2 without phase 1");

	property p_block_run;
		(ce && (hard_halt || share_hold || power_off)) |=> !run_request;
	endproperty
	a_block_run: assert property (p_block_run) else $error("run request not dropped");

	property p_halt_ring;
		(ce && hard_halt) |=> (!phase_1 && !phase_2 && !phase_3);
	endproperty
	a_halt_ring: assert property (p_halt_ring) else $error("halt left latches on");

	property p_stop_line;
		(ce && (!run_stop_n || !run_reset_n)) |=> !run_latch;
	endproperty
	a_stop_line: assert property (p_stop_line) else $error("run latch not reset");

	property p_key_start;
		(ce && key[`CFR_KEY_START] && run_stop_n && run_reset_n && !clock_reset)
			|=> (run_latch && start_control_latch && exec_stop_sample_latch);
	endproperty
	a_key_start: assert property (p_key_start) else $error("start key not taken");

	property p_hold;
		(ce && run_latch && run_stop_n && run_reset_n && !clock_reset) |=> run_latch;
	endproperty
	a_hold: assert property (p_hold) else $error("run latch fell");

	property p_stop_s4;
		(ce && c_rise && !run_go && !clock_reset && !hard_halt && ring == `CFR_RING_S4)
			|=> (ring == `CFR_RING_RST);
	endproperty
	a_stop_s4: assert property (p_stop_s4) else $error("ring did not stop");

endmodule : cfr_clock_ring

// [include/cfr_cfg.svh]
// Constants of the processor four-phase clock ring: timing, map, fields.
// Assumes a 50 MHz pclk; included by the ring, oscillator and slot modules.
`ifndef CFR_CFG_SVH
`define CFR_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CFR_PCLK_NS     20
`define CFR_OSC_NS      500
`define CFR_OSC_CYC     (`CFR_OSC_NS / `CFR_PCLK_NS)
`define CFR_OSC_HI_CYC  ((`CFR_OSC_CYC + 1) / 2)
`define CFR_DLY_NS      40
`define CFR_DLY_CYC     ((`CFR_DLY_NS + `CFR_PCLK_NS - 1) / `CFR_PCLK_NS)
`define CFR_CNT_W       5

// ----------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------
`define CFR_ADDR_W      12
`define CFR_ADDR_CTRL   12'h000
`define CFR_ADDR_STAT   12'h004
`define CFR_KEY_START   0
`define CFR_KEY_LOAD    1
`define CFR_KEY_ALOAD   2
`define CFR_ST_RUNL     0
`define CFR_ST_RUNR     1
`define CFR_ST_RING_LO  2
`define CFR_ST_RING_HI  5
`define CFR_ST_SCTL     6
`define CFR_ST_EXEC     7
`define CFR_ST_LOAD     8
`define CFR_ST_FAL      9
`define CFR_ST_SLOT_LO  10
`define CFR_ST_SLOT_HI  11
`define CFR_ST_REF      12
`define CFR_ST_REF_N    13

// ----------------------------------------------------------------
// Ring encodings (bit 0 is latch 1)
// ----------------------------------------------------------------
`define CFR_RING_RST    4'h8
`define CFR_RING_S4     4'hC

`endif

// [include/cfr_pkg.sv]
// Types shared by the clock ring modules.
// Assumes cfr_cfg.svh is on the include path.
package cfr_pkg;

	// ----------------------------------------------------------------
	// Slot index, Gray coded along the 1-2-3-4 path
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CFR_SLOT_1 = 2'h0,
		CFR_SLOT_2 = 2'h1,
		CFR_SLOT_3 = 2'h3,
		CFR_SLOT_4 = 2'h2
	} cfr_slot_t;

	// Four ring latches, bit 0 is latch 1
	typedef logic [3:0] cfr_ring_t;

endpackage : cfr_pkg

// [include/cfr_clk_if.sv]
// Oscillator drive lines and phase distribution lines of the clock ring.
// Assumes one pclk domain; every signal is a level.
`timescale 1ns/1ps

interface cfr_clk_if;
	logic             ref_osc;    // Reference oscillator, true
	logic             ref_osc_n;  // Reference oscillator, complement
	logic             dly_osc;    // Delayed oscillator, true
	logic             dly_osc_n;  // Delayed oscillator, complement
	cfr_pkg::cfr_ring_t phase;    // Phase distribution lines

	modport osc_src (output ref_osc, ref_osc_n, dly_osc, dly_osc_n);
	modport ring    (input ref_osc, ref_osc_n, dly_osc, dly_osc_n, output phase);
	modport sink    (input phase);
endinterface : cfr_clk_if

// [verilog/cfr_osc.sv]
// Oscillator model: 2 MHz reference and its delayed copy, both polarities.
// Assumes pclk at 50 MHz; ce low freezes the oscillator.
`timescale 1ns/1ps
`include "cfr_cfg.svh"

module cfr_osc (
	// Clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	input  wire logic  ce,
	// Drive lines
	cfr_clk_if.osc_src bus
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [`CFR_CNT_W-1:0]   cnt;       // Position in one oscillator period
	logic [`CFR_CNT_W-1:0]   next_cnt;
	logic                    ref_q;     // Reference level
	logic                    next_ref;
	logic [`CFR_DLY_CYC-1:0] dly_sh;    // Delay line for the delayed copy
	logic [`CFR_DLY_CYC-1:0] next_dly_sh;

	// Period is odd in pclk cycles, so high lasts one cycle longer
	always_comb begin
		next_cnt = (cnt == `CFR_CNT_W'(`CFR_OSC_CYC - 1)) ? '0 : cnt + `CFR_CNT_W'(1);
		next_ref = (next_cnt < `CFR_CNT_W'(`CFR_OSC_HI_CYC));
		next_dly_sh = {dly_sh[`CFR_DLY_CYC-2:0], ref_q};
	end

	// Registers only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt    <= '0;
			ref_q  <= 1'b0;
			dly_sh <= '0;
		end else if (ce) begin
			cnt    <= next_cnt;
			ref_q  <= next_ref;
			dly_sh <= next_dly_sh;
		end
	end

	// True and complement of both lines
	assign bus.ref_osc   = ref_q;
	assign bus.ref_osc_n = ~ref_q;
	assign bus.dly_osc   = dly_sh[`CFR_DLY_CYC-1];
	assign bus.dly_osc_n = ~dly_sh[`CFR_DLY_CYC-1];

endmodule : cfr_osc

// [verilog/cfr_slot_gen.sv]
// Sub-distribution point: pairs of overlapping phases form timing slots.
// Assumes phase lines from the ring in the same pclk domain.
`timescale 1ns/1ps
`include "cfr_cfg.svh"

module cfr_slot_gen (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	input  wire logic       ce,
	// Phase lines
	cfr_clk_if.sink         bus,
	// Slots for processor logic and multiplexor channel
	output logic      [3:0] cpu_slot,
	output logic      [3:0] chan_slot
);

	// ----------------------------------------------------------------
	// Slot decode
	// ----------------------------------------------------------------
	logic [3:0] next_slot;  // Overlap of phase i and phase i-1

	// Slot 1 = phase 1 & 4, slot n = phase n & phase n-1
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_slot
			assign next_slot[i] = bus.phase[i] & bus.phase[(i + 3) % 4];
		end
	endgenerate

	// Two copies so channel loading never skews processor timing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_slot  <= 4'h0;
			chan_slot <= 4'h0;
		end else if (ce) begin
			cpu_slot  <= next_slot;
			chan_slot <= next_slot;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_slot_one;
		@(posedge pclk) disable iff (!presetn)
		(ce && bus.phase == 4'h9) |=> (cpu_slot == 4'h1 && chan_slot == 4'h1);
	endproperty
	a_slot_one: assert property (p_slot_one) else $error("slot 1 not formed");

	property p_slot_three;
		@(posedge pclk) disable iff (!presetn)
		(ce && bus.phase == 4'h6) |=> (cpu_slot == 4'h4);
	endproperty
	a_slot_three: assert property (p_slot_three) else $error("slot 3 not formed");

endmodule : cfr_slot_gen

// [verif/cfr_proc_sink.sv]
// Model of the slot consumers: processor logic and multiplexor channel.
// Assumes phase lines and slots from the ring in the pclk domain.
`timescale 1ns/1ps

module cfr_proc_sink (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Phase lines and slots
	input  wire logic [3:0] phases,
	input  wire logic [3:0] cpu_slot,
	input  wire logic [3:0] chan_slot,
	// Command from the bench
	input  wire logic       want_extend,
	// Request and findings
	output logic            io_run_extend,
	output logic      [3:0] last_slot,
	output int              bad_cnt
);
	logic [3:0] prev_ph;  // Phases seen one edge ago
	logic [3:0] exp_slot; // Slots expected from those phases

	// Slots are formed from overlapping phase pairs
	assign exp_slot = {prev_ph[3] & prev_ph[2], prev_ph[2] & prev_ph[1],
		prev_ph[1] & prev_ph[0], prev_ph[3] & prev_ph[0]};

	// Request changes only after an edge; consumers judge every cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_run_extend <= 1'b0;
			last_slot     <= 4'h0;
			bad_cnt       <= 0;
			prev_ph       <= 4'h8;
		end else begin
			io_run_extend <= want_extend;
			if (cpu_slot !== exp_slot) begin
				bad_cnt <= bad_cnt + 1;
			end else if (chan_slot !== cpu_slot) begin
				bad_cnt <= bad_cnt + 1;
			end else if ($countones(phases) > 2) begin
				bad_cnt <= bad_cnt + 1;
			end
			// Remember the last slot seen, to judge where the ring parks
			if (cpu_slot != 4'h0) begin
				last_slot <= cpu_slot;
			end
			prev_ph <= phases;
		end
	end
endmodule : cfr_proc_sink

// [verif/cfr_clock_ring_bench.sv]
// Self-checking bench of the four-phase clock ring: keys, run control, slots.
// Assumes cfr_proc_sink as slot consumer and a 50 MHz pclk.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin error_cnt++; $display("unexpected at %0t: %s", $time, msg); end end

module cfr_clock_ring_bench;
	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	logic        pclk, presetn, ce, psel, penable, pwrite;     // Clock, APB
	logic [11:0] paddr;                                        // APB address
	logic [31:0] pwdata, prdata;                               // APB data
	logic        pready, pslverr;                              // APB answer
	logic        clock_reset, run_stop_n, run_reset_n;         // Run control
	logic        hard_halt, share_hold, power_off, io_ext;     // Run gates
	logic        phase_1, phase_2, phase_3, phase_4;           // Phases
	logic [3:0]  cpu_slot, chan_slot, last_slot, ph;           // Slots
	logic        run_request, sc_l, ex_l, ld_l, fa_l, want_ext; // Latches
	logic [31:0] rd;                                           // Read data
	logic        err, ok;                                      // Task results
	int          bad_cnt, error_cnt, samples_checked;          // Counters

	assign ph = {phase_4, phase_3, phase_2, phase_1};

	cfr_clock_ring uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_reset(clock_reset),
		.run_stop_n(run_stop_n), .run_reset_n(run_reset_n), .hard_halt(hard_halt),
		.share_hold(share_hold), .power_off(power_off), .io_run_extend(io_ext),
		.phase_1(phase_1), .phase_2(phase_2), .phase_3(phase_3), .phase_4(phase_4),
		.cpu_slot(cpu_slot), .chan_slot(chan_slot), .run_request(run_request),
		.start_control_latch(sc_l), .exec_stop_sample_latch(ex_l), .load_latch(ld_l),
		.forced_address_load_request(fa_l));

	cfr_proc_sink sink (.pclk(pclk), .presetn(presetn), .phases(ph), .cpu_slot(cpu_slot),
		.chan_slot(chan_slot), .want_extend(want_ext), .io_run_extend(io_ext),
		.last_slot(last_slot), .bad_cnt(bad_cnt));

	// 20 ns clock
	always #10 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Bus and wait helpers
	// ----------------------------------------------------------------
	// One APB transfer; request held until pready is seen high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) `CHK(pready, 1'b1, "no ready")
	endtask : apb

	// Let n edges pass; reads then see the values that stood before the edge
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	// Wait for a rising phase 1, bounded
	task automatic wait_ph1();
		logic was;
		int n;
		was = phase_1;
		ok = 1'b0;
		for (n = 0; n < 120 && !ok; n++) begin
			tick(1);
			ok = phase_1 && !was;
			was = phase_1;
		end
	endtask : wait_ph1

	// Wait for the ring to park on phase 4 alone, bounded
	task automatic wait_park();
		int n;
		ok = 1'b0;
		for (n = 0; n < 120 && !ok; n++) begin
			tick(1);
			ok = (ph === 4'h8);
		end
	endtask : wait_park

	// One-edge clock reset
	task automatic clk_rst();
		@(posedge pclk);
		clock_reset <= 1'b1;
		tick(1);
		clock_reset <= 1'b0;
		tick(1);
	endtask : clk_rst

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Each key sets run and its own side latch; run line one edge later
	task automatic t_keys();
		logic [3:0] exp_side [3] = '{4'hC, 4'h2, 4'h1};
		for (int k = 0; k < 3; k++) begin
			clk_rst();
			apb(1'b1, 12'h000, 32'h1 << k);
			`CHK(run_request, 1'b0, "run line early")
			tick(1);
			`CHK(run_request, 1'b1, "run line missing")
			`CHK({sc_l, ex_l, ld_l, fa_l}, exp_side[k], "side latch")
		end
	endtask : t_keys

	// Phase width and period, drive lines complementary
	task automatic t_timing();
		int hi;
		int per;
		wait_ph1();
		hi = 1;
		per = 1;
		while (per < 200) begin
			tick(1);
			if (phase_1 && hi != per) break;
			per++;
			if (phase_1) hi++;
		end
		`CHK(hi, 25, "phase width")
		`CHK(per, 50, "ring period")
		repeat (4) begin
			apb(1'b0, 12'h004, 32'h0);
			`CHK(rd[13], ~rd[12], "drive lines")
		end
	endtask : t_timing

	// Stop line or reset line pulse: latch drops, ring ends at slot 4
	task automatic t_stop(input int line);
		apb(1'b1, 12'h000, 32'h1);
		wait_ph1();
		if (line == 0) run_stop_n <= 1'b0;
		else run_reset_n <= 1'b0;
		tick(1);
		run_stop_n <= 1'b1;
		run_reset_n <= 1'b1;
		apb(1'b0, 12'h004, 32'h0);
		`CHK(rd[0], 1'b0, "run latch kept")
		wait_park();
		`CHK(ok, 1'b1, "no park")
		`CHK(last_slot, 4'h8, "park slot")
		tick(100);
		`CHK(ph, 4'h8, "restart")
	endtask : t_stop

	// Hard halt clears latches 1-3 at once; gates drop run, latch holds
	task automatic t_halt();
		apb(1'b1, 12'h000, 32'h1);
		wait_ph1();
		tick(5);
		hard_halt <= 1'b1;
		tick(2);
		`CHK(ph, 4'h8, "halt ring")
		`CHK(run_request, 1'b0, "halt run")
		hard_halt <= 1'b0;
		wait_ph1();
		`CHK(ok, 1'b1, "no resume")
		for (int g = 0; g < 2; g++) begin
			wait_ph1();
			if (g == 0) share_hold <= 1'b1;
			else power_off <= 1'b1;
			tick(3);
			`CHK(run_request, 1'b0, "gate run")
			wait_park();
			`CHK(ok, 1'b1, "gate park")
			share_hold <= 1'b0;
			power_off <= 1'b0;
			tick(3);
			`CHK(run_request, 1'b1, "gate back")
		end
	endtask : t_halt

	// I/O keeps the ring going after a stop, then it parks
	task automatic t_extend();
		want_ext <= 1'b1;
		run_stop_n <= 1'b0;
		tick(1);
		run_stop_n <= 1'b1;
		wait_ph1();
		wait_ph1();
		`CHK(ok, 1'b1, "no extension")
		want_ext <= 1'b0;
		wait_park();
		`CHK(ok, 1'b1, "no park")
	endtask : t_extend

	// Clock reset mid-run; unmapped and read-only accesses
	task automatic t_misc();
		apb(1'b1, 12'h000, 32'h1);
		wait_ph1();
		tick(10);
		clk_rst();
		`CHK(ph, 4'h8, "clock reset ring")
		tick(2);
		`CHK({run_request, sc_l, ex_l}, 3'h0, "clock reset run")
		apb(1'b1, 12'hFFC, 32'h1);
		`CHK(err, 1'b1, "unmapped write")
		apb(1'b1, 12'h004, 32'hFFFFFFFF);
		`CHK(err, 1'b0, "status write")
		apb(1'b0, 12'h008, 32'h0);
		`CHK(err, 1'b1, "unmapped read")
		apb(1'b0, 12'h000, 32'h0);
		`CHK(rd, 32'h0, "key read")
		apb(1'b0, 12'h004, 32'h0);
		`CHK({rd[5:2], rd[0]}, 5'h10, "no effect")
	endtask : t_misc

	// ----------------------------------------------------------------
	// Verdict and main sequence
	// ----------------------------------------------------------------
	task automatic complete_run();
		$display("errors %0d, checks %0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : complete_run

	// Watchdog well beyond the expected run of about 880 cycles
	initial begin
		#400000;
		error_cnt++;
		$display("unexpected at %0t: watchdog expired", $time);
		complete_run();
	end

	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{clock_reset, hard_halt, share_hold, power_off, want_ext} = '0;
		{ce, run_stop_n, run_reset_n} = 3'h7;
		error_cnt = 0;
		samples_checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		tick(1);
		`CHK(ph, 4'h8, "reset ring")
		`CHK({run_request, sc_l, ex_l, ld_l, fa_l}, 5'h0, "reset latches")
		t_keys();
		t_timing();
		t_stop(0);
		t_stop(1);
		t_halt();
		t_extend();
		t_misc();
		`CHK(bad_cnt, 0, "slot or overlap fault")
		complete_run();
	end
endmodule : cfr_clock_ring_bench
